// File: system_clock_source_select.sv
// How it works
// [R1] Default mode: system clock 12, 13 or 19.2 MHz from oscillator pad or external.
// [R2] Dedicated clock ball reaches clock tree only when pin-mux field holds 110.
// [R3] Software sets pin-mux 110 before writing compatibility pattern in alternate mode.
// [R4] Main oscillator runs only while its power-down bit is 0.
// [R5] Tri-state bit at 1 disables oscillator even with power-down at 0.
// [R6] Tri-state bit at 1 turns oscillator input pad into a driven-low output.
// [R7] Alternate mode skips oscillator start-up delay; clock released at once.
// [R8] Alternate mode forces oscillator into low power, never used as source.
// [R9] Alternate mode supports only 19.2 MHz through the dedicated clock ball.
// [R10] Every output clock gated by hardware sleep or by software bit; only the four derived clocks are gated here, sysclk_o is not.
// [R11] Fixed peripheral clock derived from reference system clock, gateable.
// [R12] Divided peripheral clock made by dividing first generator output, gateable.
// [R13] Camera clock control bit 2 set holds GPIO functional clock idle.
// [R14] Serial display clock divided 1 to 8 by select bits 19:17.
// [R15] After reset delay timer loads 32 ms, withholds system clock until zero.
// [R16] Source mux picks dedicated ball in alternate mode, pad otherwise, when stable.
`timescale 1ns/1ps
`include "clk_src_cfg.svh"

module system_clock_source_select
  import clk_src_pkg::*;
#(
  parameter int unsigned OSC_DELAY_CYCLES = `OSC_DELAY_CYCLES
) (
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        reset_mode_i,
  input  wire logic        dedicated_sysclk_input_i,
  input  wire logic        main_osc_input_pad_i,
  output logic             main_osc_input_pad_o,
  output logic             main_osc_input_pad_oe_o,
  input  wire logic        pm_sleep_i,
  input  wire logic        first_clock_generator_out_i,
  output logic             sysclk_o,
  output logic             sysclk_released_o,
  output logic             main_osc_enable_o,
  output logic             main_osc_lowpower_o,
  output logic             sysclk_ball_routed_o,
  output logic             fixed_cpu_periph_clock_o,
  output logic             divided_cpu_periph_clock_o,
  output logic             gpio_func_clock_o,
  output logic             serial_display_interface_clock_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [2:0] div_step(input logic [2:0] cnt, input logic [2:0] lim);
    div_step = (cnt >= lim) ? 3'h0 : 3'(cnt + 3'h1);
  endfunction : div_step

  localparam logic [31:0] DELAY_LOAD = 32'(OSC_DELAY_CYCLES);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
    end else begin
      pin_meta_r <= {pm_sleep_i, main_osc_input_pad_i, dedicated_sysclk_input_i, reset_mode_i};
      pin_sync_r <= pin_meta_r;
    end
  end

  logic mode_sync;
  logic ded_sync;
  logic pad_sync;
  logic sleep_sync;
  assign mode_sync  = pin_sync_r[0];
  assign ded_sync   = pin_sync_r[1];
  assign pad_sync   = pin_sync_r[2];
  assign sleep_sync = pin_sync_r[3];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [2:0]  pin_mux_field_d_r;
  logic [31:0] module_config_reg_one_r;
  logic [31:0] camera_clock_control_r;
  logic [7:0]  gate_ctrl_r;
  logic [31:0] compat_mode_r;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pin_mux_field_d_r       <= `PIN_MUX_OTHER;
      module_config_reg_one_r <= `MOD_CONF_RESET;
      camera_clock_control_r  <= 32'h0;
      gate_ctrl_r             <= `GATE_CTRL_RESET;
      compat_mode_r           <= 32'h0;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `OFS_PIN_MUX_D:    pin_mux_field_d_r       <= reg_wdata_i[2:0];
        `OFS_MOD_CONF_ONE: module_config_reg_one_r <= reg_wdata_i;
        `OFS_CAMERA_CLOCK_CONTROL: camera_clock_control_r  <= reg_wdata_i;
        `OFS_GATE_CTRL:    gate_ctrl_r             <= reg_wdata_i[7:0];
        `OFS_COMPAT_MODE:  compat_mode_r           <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  logic       osc_pwrdn;
  logic       osc_tri;
  logic [2:0] sdi_ratio;
  logic [2:0] per_ratio;
  logic [1:0] freq_cfg;
  logic       mux_is_sysclk;
  assign osc_pwrdn     = module_config_reg_one_r[`BIT_OSC_PWRDN];
  assign osc_tri       = module_config_reg_one_r[`BIT_OSC_TRISTATE];
  assign sdi_ratio     = module_config_reg_one_r[`FLD_SDI_DIV_HI:`FLD_SDI_DIV_LO];
  assign per_ratio     = {1'b0, module_config_reg_one_r[`FLD_PER_DIV_HI:`FLD_PER_DIV_LO]};
  assign freq_cfg      = module_config_reg_one_r[`FLD_FREQ_HI:`FLD_FREQ_LO];
  assign mux_is_sysclk = (pin_mux_field_d_r == `PIN_MUX_SYSCLK); // [R2]

  // ----------------------------------------
  // Reset mode, held until stable
  // ----------------------------------------
  // A glitch on the mode strap must not flip the clock source mid-cycle
  logic       sel_mode_r;
  logic       mode_prev_r;
  logic [2:0] mode_stable_r;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      mode_prev_r   <= 1'b0;
      mode_stable_r <= 3'h0;
    end else begin
      mode_prev_r   <= mode_sync;
      if (mode_sync != mode_prev_r) begin
        mode_stable_r <= 3'h0;
      end else if (mode_stable_r != `MODE_STABLE_CNT) begin
        mode_stable_r <= 3'(mode_stable_r + 3'h1);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sel_mode_r <= 1'b0;
    end else if (mode_stable_r == `MODE_STABLE_CNT) begin
      sel_mode_r <= mode_prev_r; // [R16]
    end
  end

  // ----------------------------------------
  // Oscillator start-up delay
  // ----------------------------------------
  tmr_state_t  tmr_state_r;
  logic [31:0] delay_cnt_r;
  logic        released;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      delay_cnt_r <= DELAY_LOAD; // [R15]
    end else if (reg_wr_i && reg_addr_i == `OFS_OSC_DELAY) begin
      delay_cnt_r <= reg_wdata_i;
    end else if (delay_cnt_r != 32'h0) begin
      delay_cnt_r <= delay_cnt_r - 32'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tmr_state_r <= TMR_HOLD;
    end else begin
      unique case (tmr_state_r)
        TMR_HOLD: if (delay_cnt_r == 32'h0) tmr_state_r <= TMR_DONE; // [R15]
        TMR_DONE: tmr_state_r <= TMR_DONE;
      endcase
    end
  end

  // Alternate mode never waits on the timer
  assign released = (tmr_state_r == TMR_DONE) || sel_mode_r; // [R7]

  // ----------------------------------------
  // Source selection and pads
  // ----------------------------------------
  logic src_level;
  logic src_prev_r;
  logic src_tick;
  assign src_level = sel_mode_r ? (ded_sync & mux_is_sysclk) // [R9] [R16]
                                : (pad_sync & ~osc_tri);     // [R1] [R16]

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= src_level;
    end
  end

  assign src_tick = src_level & ~src_prev_r & released;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sysclk_o             <= 1'b0;
      sysclk_released_o    <= 1'b0;
      main_osc_enable_o    <= 1'b0;
      main_osc_lowpower_o  <= 1'b0;
      sysclk_ball_routed_o <= 1'b0;
    end else begin
      sysclk_o             <= src_level & released; // [R15]
      sysclk_released_o    <= released;
      main_osc_enable_o    <= ~osc_pwrdn & ~osc_tri & ~sel_mode_r; // [R4] [R5] [R8]
      main_osc_lowpower_o  <= sel_mode_r; // [R8]
      sysclk_ball_routed_o <= mux_is_sysclk; // [R2] [R3]
    end
  end

  // Pad driven low, so board pulldown sees no contention
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      main_osc_input_pad_o    <= 1'b0;
      main_osc_input_pad_oe_o <= 1'b0;
    end else begin
      main_osc_input_pad_o    <= 1'b0;
      main_osc_input_pad_oe_o <= osc_tri; // [R6]
    end
  end

  // ----------------------------------------
  // Derived clock enables and gating
  // ----------------------------------------
  clk_gate_t sw_run;
  clk_gate_t hw_sel;
  clk_gate_t run;
  assign sw_run = gate_ctrl_r[3:0];
  assign hw_sel = gate_ctrl_r[7:4];
  assign run    = (hw_sel & {4{~sleep_sync}}) | (~hw_sel & sw_run); // [R10]

  logic [2:0] per_cnt_r;
  logic [2:0] sdi_cnt_r;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      per_cnt_r <= 3'h0;
    end else if (first_clock_generator_out_i) begin
      per_cnt_r <= div_step(per_cnt_r, per_ratio); // [R12]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sdi_cnt_r <= 3'h0;
    end else if (src_tick) begin
      sdi_cnt_r <= div_step(sdi_cnt_r, sdi_ratio); // [R14]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      fixed_cpu_periph_clock_o         <= 1'b0;
      divided_cpu_periph_clock_o       <= 1'b0;
      gpio_func_clock_o                <= 1'b0;
      serial_display_interface_clock_o <= 1'b0;
    end else begin
      fixed_cpu_periph_clock_o         <= src_tick & run.fixed; // [R11]
      divided_cpu_periph_clock_o       <= first_clock_generator_out_i & (per_cnt_r == per_ratio)
                                          & run.divided; // [R12]
      gpio_func_clock_o                <= src_tick & run.gpio
                                          & ~camera_clock_control_r[`BIT_GPIO_IDLE]; // [R13]
      serial_display_interface_clock_o <= src_tick & (sdi_cnt_r == sdi_ratio) & run.sdi; // [R14]
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [1:0]  freq_eff;
  logic [31:0] status;
  logic [31:0] rdata_nxt;
  assign freq_eff = sel_mode_r ? `FREQ_19M2HZ : freq_cfg; // [R1] [R9]
  assign status   = {24'h0, freq_eff, mux_is_sysclk, src_level,
                     main_osc_enable_o, released, tmr_state_r, sel_mode_r};

  always_comb begin
    rdata_nxt = 32'h0;
    unique case (reg_addr_i)
      `OFS_PIN_MUX_D:    rdata_nxt = {29'h0, pin_mux_field_d_r};
      `OFS_MOD_CONF_ONE: rdata_nxt = module_config_reg_one_r;
      `OFS_CAMERA_CLOCK_CONTROL: rdata_nxt = camera_clock_control_r;
      `OFS_GATE_CTRL:    rdata_nxt = {24'h0, gate_ctrl_r};
      `OFS_OSC_DELAY:    rdata_nxt = delay_cnt_r;
      `OFS_STATUS:       rdata_nxt = status;
      `OFS_COMPAT_MODE:  rdata_nxt = compat_mode_r;
      default:           rdata_nxt = 32'h0;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 32'h0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_nxt : 32'h0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  chk_osc_powerdown: assert property (osc_pwrdn |=> !main_osc_enable_o) // [R4]
    else $error("oscillator enabled while powered down");
  chk_osc_run: assert property (!osc_pwrdn && !osc_tri && !sel_mode_r |=> main_osc_enable_o) // [R4]
    else $error("oscillator not enabled");
  chk_osc_tristate: assert property (osc_tri |=> !main_osc_enable_o) // [R5]
    else $error("oscillator enabled while tri-stated");
  chk_pad_drive_low: assert property (osc_tri |=> main_osc_input_pad_oe_o && !main_osc_input_pad_o) // [R6]
    else $error("pad not driven low");
  chk_mux_route: assert property (mux_is_sysclk != $past(mux_is_sysclk) |=> sysclk_ball_routed_o == $past(mux_is_sysclk)) // [R2]
    else $error("ball routing mismatch");
  chk_delay_bypass: assert property (sel_mode_r |=> sysclk_released_o) // [R7]
    else $error("alternate mode waits on delay");
  chk_lowpower_force: assert property (sel_mode_r |=> main_osc_lowpower_o && !main_osc_enable_o) // [R8]
    else $error("oscillator not forced low power");
  chk_hold_clock: assert property (delay_cnt_r > 32'h1 && !sel_mode_r && tmr_state_r == TMR_HOLD
                                   |=> !sysclk_o ##1 ($past(sel_mode_r) || !sysclk_o)) // [R15]
    else $error("system clock leaked during delay");
  chk_gpio_idle: assert property (camera_clock_control_r[`BIT_GPIO_IDLE] |=> !gpio_func_clock_o) // [R13]
    else $error("gpio clock runs while idle");
  chk_sdi_ratio: assert property (serial_display_interface_clock_o && sdi_ratio == $past(sdi_ratio)
                                  && sdi_ratio != 3'h0 |=> !serial_display_interface_clock_o) // [R14]
    else $error("serial display clock too fast");
  chk_gate_sw: assert property (!hw_sel.fixed && !sw_run.fixed |=> !fixed_cpu_periph_clock_o) // [R10]
    else $error("gated clock still runs");
  chk_mode_stable: assert property ($changed(sel_mode_r) && !$past(srst_i) // [R16]
                                    |-> $past(mode_prev_r, 2) == $past(mode_prev_r, 1))
    else $error("source switched on unstable mode");

  cov_release: cover property (tmr_state_r == TMR_HOLD ##1 tmr_state_r == TMR_DONE);
  cov_alt_mode: cover property (sel_mode_r && mux_is_sysclk && sysclk_o);
  cov_sdi_div8: cover property (sdi_ratio == 3'h7 && serial_display_interface_clock_o);

endmodule : system_clock_source_select

// File: clk_src_cfg.svh
`ifndef CLK_SRC_CFG_SVH
`define CLK_SRC_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_PIN_MUX_D     8'h00
`define OFS_MOD_CONF_ONE  8'h04
`define OFS_CAMERA_CLOCK_CONTROL  8'h08
`define OFS_GATE_CTRL     8'h0c
`define OFS_OSC_DELAY     8'h10
`define OFS_STATUS        8'h14
`define OFS_COMPAT_MODE   8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_OSC_PWRDN     0
`define BIT_OSC_TRISTATE  1
`define FLD_SDI_DIV_HI    19
`define FLD_SDI_DIV_LO    17
`define FLD_PER_DIV_HI    21
`define FLD_PER_DIV_LO    20
`define FLD_FREQ_HI       23
`define FLD_FREQ_LO       22
`define BIT_GPIO_IDLE     2

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define PIN_MUX_OTHER     3'h0
`define PIN_MUX_SYSCLK    3'h6
`define MOD_CONF_RESET    32'h0000_0000
`define GATE_CTRL_RESET   8'h0f
`define FREQ_12MHZ        2'h0
`define FREQ_13MHZ        2'h1
`define FREQ_19M2HZ       2'h2
`define MODE_STABLE_CNT   3'h4

// ----------------------------------------
// Timing
// ----------------------------------------
`define REF_CLK_KHZ       125000
`define OSC_DELAY_MS      32
`define OSC_DELAY_CYCLES  (`OSC_DELAY_MS * `REF_CLK_KHZ)

`endif

// File: clk_src_pkg.sv
package clk_src_pkg;

  typedef enum logic {
    TMR_HOLD = 1'b0,
    TMR_DONE = 1'b1
  } tmr_state_t;

  typedef struct packed {
    logic sdi;
    logic gpio;
    logic divided;
    logic fixed;
  } clk_gate_t;

endpackage : clk_src_pkg

// File: clk_far_side.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far side: crystal/pad, external ball and first generator
// ----------------------------------------
module clk_far_side (
  input  wire logic ref_clk_i,
  input  wire logic osc_run_i,
  input  wire logic ball_run_i,
  input  wire logic pad_drive_i,
  input  wire logic pad_oe_i,
  output logic      pad_level_o,
  output logic      ball_level_o,
  output logic      gen_pulse_o
);
  logic [1:0] ph_r;
  logic       osc_r;

  initial begin
    ph_r         = 2'h0;
    osc_r        = 1'b0;
    ball_level_o = 1'b0;
    gen_pulse_o  = 1'b0;
  end

  // Pad and ball sources toggle every 3 cycles, the generator every cycle; stopped ones fall to the pulldown level
  always @(posedge ref_clk_i) begin
    ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
    if (ph_r == 2'h2) begin
      osc_r        <= osc_run_i & ~osc_r;
      ball_level_o <= ball_run_i & ~ball_level_o;
    end
    gen_pulse_o <= ~gen_pulse_o;
  end

  // Pulldown on the pad; device drive wins when enabled
  assign pad_level_o = pad_oe_i ? pad_drive_i : osc_r;
endmodule : clk_far_side

// File: system_clock_source_select_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module system_clock_source_select_tb;
  logic        ref_clk_i = 1'b0, srst_i = 1'b1;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, rd;
  logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0, reset_mode_i = 1'b0;
  logic        pm_sleep_i = 1'b0, osc_run = 1'b1, ball_run = 1'b0;
  logic        pad_lvl, ball_lvl, gen, pad_o, pad_oe, sysclk_o, rel_o;
  logic        osc_en_o, lowp_o, routed_o, fix_o, div_o, gpio_o, sdi_o;
  logic        counting = 1'b0, sys_q = 1'b0;
  int          miscompares = 0, check_count = 0;
  int          n_fix, n_div, n_gpio, n_sdi, n_gen, n_sys;
  logic [31:0] rows [6][3] = '{'{8'h00, 3'h6, 3'h6}, '{8'h08, 8'h4, 8'h4},
    '{8'h0c, 8'h0f, 8'h0f}, '{8'h18, 32'heaef, 32'heaef},
    '{8'h04, 32'h0080_0000, 32'h0080_0000}, '{8'h40, 8'h5a, 8'h0}};

  always #4 ref_clk_i = ~ref_clk_i;

  system_clock_source_select #(.OSC_DELAY_CYCLES(200)) u_system_clock_source_select (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reset_mode_i(reset_mode_i),
    .dedicated_sysclk_input_i(ball_lvl), .main_osc_input_pad_i(pad_lvl),
    .main_osc_input_pad_o(pad_o), .main_osc_input_pad_oe_o(pad_oe),
    .pm_sleep_i(pm_sleep_i), .first_clock_generator_out_i(gen),
    .sysclk_o(sysclk_o), .sysclk_released_o(rel_o), .main_osc_enable_o(osc_en_o),
    .main_osc_lowpower_o(lowp_o), .sysclk_ball_routed_o(routed_o),
    .fixed_cpu_periph_clock_o(fix_o), .divided_cpu_periph_clock_o(div_o),
    .gpio_func_clock_o(gpio_o), .serial_display_interface_clock_o(sdi_o));

  clk_far_side u_clk_far_side (.ref_clk_i(ref_clk_i), .osc_run_i(osc_run),
    .ball_run_i(ball_run), .pad_drive_i(pad_o), .pad_oe_i(pad_oe),
    .pad_level_o(pad_lvl), .ball_level_o(ball_lvl), .gen_pulse_o(gen));

  // ----------------------------------------
  // Pulse counters
  // ----------------------------------------
  always @(posedge ref_clk_i) begin
    sys_q <= sysclk_o;
    if (counting) begin
      n_fix  += (fix_o === 1'b1);
      n_div  += (div_o === 1'b1);
      n_gpio += (gpio_o === 1'b1);
      n_sdi  += (sdi_o === 1'b1);
      n_gen  += (gen === 1'b1);
      n_sys  += (sysclk_o === 1'b1 && sys_q === 1'b0);
    end
  end

  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : check

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask : wr

  task rdreg(input logic [7:0] a);
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 rd = reg_rdata_o;
  endtask : rdreg

  // Window of 240 cycles holds 40 source edges from the far side
  task measure;
    repeat (10) @(posedge ref_clk_i);
    {n_fix, n_div, n_gpio, n_sdi, n_gen, n_sys} = '0;
    counting = 1'b1;
    repeat (240) @(posedge ref_clk_i);
    counting = 1'b0;
  endtask : measure

  task do_reset(input logic mode);
    @(posedge ref_clk_i);
    reset_mode_i <= mode;
    srst_i       <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    srst_i <= 1'b0;
  endtask : do_reset

  task conclude;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  initial begin
    #(8 * 30000);
    miscompares++;
    conclude;
  end

  initial begin
    int i;
    do_reset(1'b0);
    repeat (100) @(posedge ref_clk_i);
    `CHK("early release", 0, rel_o);
    for (i = 0; i < 300 && rel_o !== 1'b1; i++) @(posedge ref_clk_i);
    `CHK("release time", 1, (i + 100 >= 190) && (i + 100 <= 215));
    foreach (rows[k]) begin
      wr(rows[k][0][7:0], rows[k][1]);
      rdreg(rows[k][0][7:0]);
      `CHK("readback", rows[k][2], rd);
    end
    `CHK("ball routed", 1, routed_o);
    wr(8'h00, 32'h0);
    `CHK("ball unrouted", 0, routed_o);
    for (i = 0; i < 3; i++) begin
      wr(8'h04, 32'(i) << 22);
      rdreg(8'h14);
      `CHK("freq code", i, rd[7:6]);
    end
    wr(8'h08, 32'h0);
    measure;
    `CHK("fixed pulses", 1, n_fix >= 39 && n_fix <= 41);
    `CHK("gpio pulses", 1, n_gpio >= 39 && n_gpio <= 41);
    for (i = 0; i < 8; i++) begin
      wr(8'h04, 32'(i) << 17);
      measure;
      `CHK("sdi ratio", 1, n_sdi * (i + 1) >= n_fix - i - 1 && n_sdi * (i + 1) <= n_fix + i + 1);
    end
    for (i = 0; i < 4; i++) begin
      wr(8'h04, 32'(i) << 20);
      measure;
      `CHK("div ratio", 1, n_div * (i + 1) >= n_gen - i - 1 && n_div * (i + 1) <= n_gen + i + 1);
    end
    wr(8'h08, 32'h4);
    measure;
    `CHK("gpio idle", 0, n_gpio);
    wr(8'h0c, 32'h0e);
    measure;
    `CHK("fixed gated", 0, n_fix);
    wr(8'h0c, 32'hff);
    pm_sleep_i <= 1'b1;
    measure;
    `CHK("sleep gated", 0, n_fix + n_div + n_sdi);
    pm_sleep_i <= 1'b0;
    measure;
    `CHK("awake", 1, n_fix >= 39);
    `CHK("osc on", 1, osc_en_o);
    wr(8'h04, 32'h1);
    `CHK("osc powered down", 0, osc_en_o);
    wr(8'h04, 32'h2);
    `CHK("osc tristated", 0, osc_en_o);
    `CHK("pad driven", 2'h2, {pad_oe, pad_o});
    measure;
    `CHK("pad source off", 0, n_sys);
    wr(8'h04, 32'h0);
    `CHK("pad released", 0, pad_oe);
    // Alternate mode: mid-run reset, pad keeps toggling as a decoy
    do_reset(1'b1);
    for (i = 0; i < 40 && rel_o !== 1'b1; i++) @(posedge ref_clk_i);
    `CHK("no delay", 1, i < 30);
    rdreg(8'h0c);
    `CHK("gate reset", 8'h0f, rd);
    `CHK("low power", 2'h1, {osc_en_o, lowp_o});
    ball_run <= 1'b1;
    measure;
    `CHK("unrouted src", 0, n_sys);
    wr(8'h00, 32'h6);
    wr(8'h18, 32'h0000_eaef);
    measure;
    `CHK("ball source", 1, n_sys >= 39 && n_sys <= 41);
    rdreg(8'h14);
    `CHK("forced freq", 2'h2, rd[7:6]);
    ball_run <= 1'b0;
    measure;
    `CHK("osc unused", 0, n_sys);
    // Back to default mode; software cuts the start-up delay short
    do_reset(1'b0);
    rdreg(8'h10);
    `CHK("delay loaded", 1, rd >= 32'd190 && rd <= 32'd200);
    `CHK("held after reset", 0, rel_o);
    wr(8'h10, 32'h0);
    for (i = 0; i < 20 && rel_o !== 1'b1; i++) @(posedge ref_clk_i);
    `CHK("delay cut", 1, i < 5);
    rdreg(8'h10);
    `CHK("delay cleared", 0, rd);
    measure;
    `CHK("pad source", 1, n_sys >= 39 && n_sys <= 41);
    conclude;
  end
endmodule : system_clock_source_select_tb
